// ---- xic_calc.sv ----
// Calculation command interpreter for the X-register and immediate commands.
`timescale 1ns/1ps
`include "xic_map.svh"

module xic_calc
  import xic_pkg::*;
#(
  parameter logic [7:0] MOD_ADDR  = `XIC_MOD_ADDR,
  parameter logic [7:0] HOST_ADDR = `XIC_HOST_ADDR,
  parameter int         NUM_VARS  = 256
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Command byte stream from the transport.
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  // Reply byte stream to the transport.
  output logic [7:0]       tx_byte_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  // Observation of interpreter state.
  input  wire logic [7:0]  var_idx_i,
  output logic [31:0]      var_data_o,
  output logic [31:0]      xreg_o,
  output logic             flag_eq_o,
  output logic             flag_gt_o,
  output logic             flag_lt_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  // Reset asserts at once but leaves through two flops to avoid release races.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // State
  // ****************************************
  xic_state_t  state;
  logic [7:0]  frame [0:8];
  logic [7:0]  reply [0:8];
  logic [3:0]  rx_cnt;
  logic [3:0]  tx_idx;
  logic [7:0]  rx_sum;
  logic [31:0] uvar [0:NUM_VARS-1];

  // ****************************************
  // Command decode and operand path
  // ****************************************
  logic [7:0]  cmd_instr;
  logic [7:0]  cmd_bank;
  xic_op_t     cmd_op;
  logic [31:0] cmd_imm;
  logic [31:0] var_val;
  logic [31:0] lhs;
  logic [31:0] rhs;
  logic [31:0] result;
  logic        res_valid;
  logic        is_comp;
  logic        is_swap;
  logic        is_xreg;
  logic        cmd_known;
  logic        frame_ok;
  logic [7:0]  reply_status;
  logic [7:0]  reply_sum;

  assign cmd_instr = frame[`XIC_POS_INSTR];
  assign cmd_bank  = frame[`XIC_POS_BANK];
  assign cmd_op    = xic_op_t'(frame[`XIC_POS_TYPE]);
  // Value travels most significant byte first.
  assign cmd_imm   = {frame[`XIC_POS_VAL3], frame[`XIC_POS_VAL2],
                      frame[`XIC_POS_VAL1], frame[`XIC_POS_VAL0]};
  assign var_val   = uvar[cmd_bank];
  assign is_xreg   = (cmd_instr == `XIC_INSTR_XREG);
  assign cmd_known = is_xreg || (cmd_instr == `XIC_INSTR_IMM);
  // The X command ignores the value field; the immediate form uses it.
  assign lhs       = is_xreg ? xreg_o : var_val;
  assign rhs       = is_xreg ? var_val : cmd_imm;

  // Arithmetic unit; signed throughout, a zero divisor suppresses the write.
  always_comb begin
    result    = `XIC_WORD_RST;
    res_valid = 1'b1;
    is_comp   = 1'b0;
    is_swap   = 1'b0;
    unique case (cmd_op)
      XIC_OP_ADD:  result = lhs + rhs;
      XIC_OP_SUB:  result = lhs - rhs;
      XIC_OP_MUL:  result = 32'($signed(lhs) * $signed(rhs));
      XIC_OP_DIV: begin
        res_valid = (rhs != `XIC_WORD_RST);
        if (res_valid) begin
          result = $signed(lhs) / $signed(rhs);
        end
      end
      XIC_OP_MOD: begin
        res_valid = (rhs != `XIC_WORD_RST);
        if (res_valid) begin
          result = $signed(lhs) % $signed(rhs);
        end
      end
      XIC_OP_AND:  result = lhs & rhs;
      XIC_OP_OR:   result = lhs | rhs;
      XIC_OP_XOR:  result = lhs ^ rhs;
      // For the X form the inverse of the variable; for the immediate form of itself.
      XIC_OP_NOT:  result = is_xreg ? ~var_val : ~var_val;
      XIC_OP_LOAD: result = rhs;
      XIC_OP_SWAP: begin
        result    = var_val;
        is_swap   = is_xreg;
        res_valid = is_xreg;
      end
      XIC_OP_COMP: begin
        is_comp   = 1'b1;
        res_valid = 1'b0;
      end
      default:     res_valid = 1'b0;
    endcase
  end

  // Status and reply checksum for the frame being answered.
  always_comb begin
    if (!cmd_known) begin
      reply_status = `XIC_STAT_BADCMD;
    end else if (!res_valid && !is_comp && (cmd_op > XIC_OP_COMP || (cmd_op == XIC_OP_SWAP))) begin
      reply_status = `XIC_STAT_BADTYP;
    end else begin
      reply_status = `XIC_STAT_OK;
    end
    reply_sum = HOST_ADDR + MOD_ADDR + reply_status + cmd_instr
              + frame[`XIC_POS_VAL3] + frame[`XIC_POS_VAL2]
              + frame[`XIC_POS_VAL1] + frame[`XIC_POS_VAL0];
  end

  // Frame passes when its checksum and address match.
  assign frame_ok = (rx_sum == rx_byte_i) && (frame[`XIC_POS_ADDR] == MOD_ADDR);

  // ****************************************
  // Sequencer and framing
  // ****************************************
  // A frame is taken byte by byte, executed in one cycle, then answered.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= XIC_RECV;
      rx_cnt     <= 4'h0;
      rx_sum     <= 8'h00;
      tx_idx     <= 4'h0;
      rx_ready_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_byte_o  <= 8'h00;
      for (int i = 0; i < 9; i++) begin
        frame[i] <= 8'h00;
        reply[i] <= 8'h00;
      end
    end else begin
      unique case (state)
        XIC_RECV: begin
          rx_ready_o <= 1'b1;
          if (rx_valid_i && rx_ready_o) begin
            frame[rx_cnt] <= rx_byte_i;
            if (rx_cnt == `XIC_POS_CSUM) begin
              rx_cnt <= 4'h0;
              rx_sum <= 8'h00;
              // Bad frames are dropped silently; the host times out and retries.
              if (frame_ok) begin
                state      <= XIC_EXEC;
                rx_ready_o <= 1'b0;
              end
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
              rx_sum <= rx_sum + rx_byte_i;
            end
          end
        end
        XIC_EXEC: begin
          reply[0]   <= HOST_ADDR;
          reply[1]   <= MOD_ADDR;
          reply[2]   <= reply_status;
          reply[3]   <= cmd_instr;
          reply[4]   <= frame[`XIC_POS_VAL3];
          reply[5]   <= frame[`XIC_POS_VAL2];
          reply[6]   <= frame[`XIC_POS_VAL1];
          reply[7]   <= frame[`XIC_POS_VAL0];
          reply[8]   <= reply_sum;
          tx_byte_o  <= HOST_ADDR;
          tx_valid_o <= 1'b1;
          tx_idx     <= 4'h0;
          state      <= XIC_SEND;
        end
        XIC_SEND: begin
          if (tx_ready_i) begin
            if (tx_idx == `XIC_POS_CSUM) begin
              tx_valid_o <= 1'b0;
              state      <= XIC_RECV;
            end else begin
              tx_idx    <= tx_idx + 4'h1;
              tx_byte_o <= (tx_idx == `XIC_POS_ADDR) ? MOD_ADDR : reply[tx_idx + 4'h1];
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // X register, variables and flags
  // ****************************************
  logic do_exec;
  assign do_exec = (state == XIC_EXEC) && (reply_status == `XIC_STAT_OK);

  // X register takes the result of the X form, or the old variable on a swap.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xreg_o <= `XIC_WORD_RST;
    end else if (do_exec && is_xreg && res_valid) begin
      xreg_o <= result;
    end
  end

  // Variables: the immediate form writes its result, a swap writes the old X.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_VARS; i++) begin
        uvar[i] <= `XIC_WORD_RST;
      end
    end else if (do_exec && is_swap) begin
      uvar[cmd_bank] <= xreg_o;
    end else if (do_exec && !is_xreg && res_valid) begin
      uvar[cmd_bank] <= result;
    end
  end

  // Compare sets flags from the two operands; other writes compare the result with zero.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flag_eq_o <= 1'b0;
      flag_gt_o <= 1'b0;
      flag_lt_o <= 1'b0;
    end else if (do_exec && is_comp) begin
      flag_eq_o <= (lhs == rhs);
      flag_gt_o <= ($signed(lhs) > $signed(rhs));
      flag_lt_o <= ($signed(lhs) < $signed(rhs));
    end else if (do_exec && res_valid) begin
      flag_eq_o <= (result == `XIC_WORD_RST);
      flag_gt_o <= ($signed(result) > 0);
      flag_lt_o <= result[31];
    end
  end

  // Registered read port so a watcher sees variables without disturbing execution.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      var_data_o <= `XIC_WORD_RST;
    end else begin
      var_data_o <= uvar[var_idx_i];
    end
  end

endmodule

// ---- xic_map.svh ----
// Constants for the calculation command interpreter: frame layout, codes and reset values.
`ifndef XIC_MAP_SVH
`define XIC_MAP_SVH

// ****************************************
// Frame layout
// ****************************************
`define XIC_FRAME_LEN   4'd9
`define XIC_POS_ADDR    4'd0
`define XIC_POS_INSTR   4'd1
`define XIC_POS_TYPE    4'd2
`define XIC_POS_BANK    4'd3
`define XIC_POS_VAL3    4'd4
`define XIC_POS_VAL2    4'd5
`define XIC_POS_VAL1    4'd6
`define XIC_POS_VAL0    4'd7
`define XIC_POS_CSUM    4'd8

// ****************************************
// Codes and reset values
// ****************************************
`define XIC_INSTR_XREG  8'h2c
`define XIC_INSTR_IMM   8'h2d
`define XIC_STAT_OK     8'h64
`define XIC_STAT_BADCMD 8'h02
`define XIC_STAT_BADTYP 8'h03
`define XIC_HOST_ADDR   8'h02
`define XIC_MOD_ADDR    8'h01
`define XIC_WORD_RST    32'h0000_0000

`endif

// ---- xic_pkg.sv ----
// Types shared by the calculation command interpreter.
package xic_pkg;

  // Interpreter sequencing states, one-hot.
  typedef enum logic [2:0] {
    XIC_RECV = 3'b001,
    XIC_EXEC = 3'b010,
    XIC_SEND = 3'b100
  } xic_state_t;

  // Operation selected by the type byte.
  typedef enum logic [7:0] {
    XIC_OP_ADD  = 8'h00,
    XIC_OP_SUB  = 8'h01,
    XIC_OP_MUL  = 8'h02,
    XIC_OP_DIV  = 8'h03,
    XIC_OP_MOD  = 8'h04,
    XIC_OP_AND  = 8'h05,
    XIC_OP_OR   = 8'h06,
    XIC_OP_XOR  = 8'h07,
    XIC_OP_NOT  = 8'h08,
    XIC_OP_LOAD = 8'h09,
    XIC_OP_SWAP = 8'h0a,
    XIC_OP_COMP = 8'h0b
  } xic_op_t;

endpackage

// ---- xic_calc_asserts.sv ----
// Concurrent checks on the reply stream, flags and X register of the calculator.
`timescale 1ns/1ps
module xic_calc_asserts (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        rx_ready_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic [31:0] xreg_o,
  input wire logic        flag_eq_o,
  input wire logic        flag_gt_o,
  input wire logic        flag_lt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0] cnt;
  // Counts reply bytes taken, so a short or long reply shows at its end.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt <= 4'h0;
    else if (tx_valid_o && tx_ready_i) cnt <= cnt + 4'h1;
    else if (!tx_valid_o) cnt <= 4'h0;
  end
  a_tx_hold_stall: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte changed while stalled");
  a_no_rx_overlap: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("receiver ready during reply");
  a_reply_host: assert property ($rose(tx_valid_o) |-> tx_byte_o == 8'h02)
    else $error("reply does not open with host address");
  a_reply_module: assert property ($rose(tx_valid_o) && tx_ready_i |=> tx_byte_o == 8'h01)
    else $error("second reply byte is not module address");
  a_reply_len: assert property ($fell(tx_valid_o) |-> cnt == 4'h9)
    else $error("reply length is not nine bytes");
  a_reply_follows: assert property ($fell(rx_ready_o) |-> ##[1:2] (tx_valid_o || rx_ready_o))
    else $error("no reply after frame");
  a_ready_return: assert property ($fell(tx_valid_o) |-> ##[0:1] rx_ready_o)
    else $error("receiver not ready after reply");
  a_xreg_quiet: assert property ($changed(xreg_o) |-> !$past(rx_ready_o))
    else $error("X register changed outside execution");
  a_flags_single: assert property ($onehot0({flag_eq_o, flag_gt_o, flag_lt_o}))
    else $error("more than one compare flag set");
endmodule
bind xic_calc xic_calc_asserts xic_calc_asserts_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .rx_ready_o(rx_ready_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .xreg_o(xreg_o), .flag_eq_o(flag_eq_o),
  .flag_gt_o(flag_gt_o), .flag_lt_o(flag_lt_o));

// ---- xic_host.sv ----
// Host model: sends command frames and takes replies with random stalls.
`timescale 1ns/1ps
module xic_host (
  input  wire logic       clk_i,
  input  wire logic       rx_ready_o,
  input  wire logic       tx_valid_o,
  output logic [7:0]      rx_byte_i,
  output logic            rx_valid_i,
  output logic            tx_ready_i
);
  int seed = 32'h8ece;
  initial begin
    rx_byte_i = 8'h00;
    rx_valid_i = 1'b0;
    tx_ready_i = 1'b0;
  end
  // Stalls about a third of reply bytes to exercise holding.
  always @(posedge clk_i) tx_ready_i <= #1 ({$random(seed)} % 3) != 0;
  // Call just after a clock edge; err flips checksum bits on purpose.
  // Frames come one at a time as a direct-mode host would; stored programs are not modelled.
  task automatic send(input logic [7:0] adr, ins, typ, bank, input logic [31:0] val,
                      input logic [7:0] err);
    logic [7:0] b [9];
    b = '{adr, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    b[8] ^= err;
    for (int i = 0; i < 9; i++) begin
      rx_valid_i = 1'b1;
      rx_byte_i = b[i];
      do @(posedge clk_i); while (rx_ready_o !== 1'b1);
      #1;
    end
    // Idle line shows the inverse so a stale byte is never mistaken for data.
    rx_valid_i = 1'b0;
    rx_byte_i = ~rx_byte_i;
  endtask
endmodule

// ---- tb_xic_calc.sv ----
// Self-checking bench for the calculation command interpreter.
`timescale 1ns/1ps
module tb_xic_calc;
  logic        clk_i = 0;
  logic        reset_n_i = 0;
  logic [7:0]  rx_byte_i, tx_byte_o;
  logic [7:0]  var_idx_i = 8'h00;
  logic        rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic        flag_eq_o, flag_gt_o, flag_lt_o;
  logic [31:0] var_data_o, xreg_o, ex;
  logic [31:0] ev [256];
  logic [2:0]  ef;
  logic [7:0]  eq_q [$];
  int          fail_count = 0;
  int          n_tests = 0;
  int          seed = 32'h8ece;
  xic_calc xic_calc_inst (.clk_i, .reset_n_i, .rx_byte_i, .rx_valid_i, .rx_ready_o,
    .tx_byte_o, .tx_valid_o, .tx_ready_i, .var_idx_i, .var_data_o, .xreg_o,
    .flag_eq_o, .flag_gt_o, .flag_lt_o);
  xic_host xic_host_inst (.clk_i, .rx_ready_o, .tx_valid_o, .rx_byte_i, .rx_valid_i,
    .tx_ready_i);
  initial forever #10 clk_i = ~clk_i;
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Each reply byte taken is matched against the oldest noted byte.
  always @(posedge clk_i) if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
    if (eq_q.size() == 0) check("unexpected reply byte", 32'h1, 32'h0);
    else check("reply byte", 32'(tx_byte_o), 32'(eq_q.pop_front()));
  end
  // Reference model; every write, a swap too, sets the flags from the value written.
  task automatic cmd(input logic [7:0] adr, ins, typ, bank, input logic [31:0] val,
                     input logic [7:0] err);
    logic [31:0] l, r, res;
    logic [7:0]  st, rp [9];
    bit          wr;
    l = (ins == 8'h2c) ? ex : ev[bank];
    r = (ins == 8'h2c) ? ev[bank] : val;
    res = l;
    st = 8'h64;
    wr = (typ != 8'd11);
    case (typ)
      8'd0: res = l + r;
      8'd1: res = l - r;
      8'd2: res = l * r;
      8'd3: res = $signed(l) / $signed(r);
      8'd4: res = $signed(l) % $signed(r);
      8'd5: res = l & r;
      8'd6: res = l | r;
      8'd7: res = l ^ r;
      8'd8: res = (ins == 8'h2c) ? ~r : ~l;
      8'd9: res = r;
      8'd10: res = r;
      8'd11: res = l;
      default: st = 8'h03;
    endcase
    if ((typ == 8'd3 || typ == 8'd4) && r == 0) wr = 0;
    if (typ == 8'd10 && ins == 8'h2d) st = 8'h03;
    if (ins != 8'h2c && ins != 8'h2d) st = 8'h02;
    if (adr == 8'h01 && err == 8'h00) begin
      if (st == 8'h64 && typ == 8'd11) ef = {l == r, $signed(l) > $signed(r), $signed(l) < $signed(r)};
      else if (st == 8'h64 && wr) begin
        ef = {res == 0, $signed(res) > 0, $signed(res) < 0};
        if (typ == 8'd10) ev[bank] = l;
        if (ins == 8'h2c) ex = res;
        else ev[bank] = res;
      end
      rp = '{8'h02, 8'h01, st, ins, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) rp[8] += rp[i];
      foreach (rp[i]) eq_q.push_back(rp[i]);
    end
    xic_host_inst.send(adr, ins, typ, bank, val, err);
    repeat (3) @(posedge clk_i);
    while (eq_q.size() != 0 || tx_valid_o !== 1'b0) @(posedge clk_i);
    #1 var_idx_i = bank;
    repeat (2) @(posedge clk_i);
    #1;
    check("user variable", var_data_o, ev[bank]);
    check("x register", xreg_o, ex);
    check("flags", 32'({flag_eq_o, flag_gt_o, flag_lt_o}), 32'(ef));
  endtask
  // Main sequence: every code and type pairing, then refused and unknown frames.
  initial begin
    ex = 0;
    ef = 0;
    foreach (ev[i]) ev[i] = 0;
    repeat (6) @(posedge clk_i);
    #1 reset_n_i = 1;
    repeat (4) @(posedge clk_i);
    #1;
    for (int k = 0; k < 78; k++) begin
      cmd(8'h01, k[0] ? 8'h2d : 8'h2c, 8'(k % 13), ({$random(seed)} % 2) ? 8'hff : 8'h03,
          $random(seed) >>> ({$random(seed)} % 32), 8'h00);
    end
    // Zero divisors on both forms must leave destination and flags alone.
    cmd(8'h01, 8'h2d, 8'h03, 8'h03, 32'h0000_0000, 8'h00);
    cmd(8'h01, 8'h2d, 8'h04, 8'hff, 32'h0000_0000, 8'h00);
    cmd(8'h01, 8'h2c, 8'h03, 8'h10, 32'h0000_0007, 8'h00);
    cmd(8'h01, 8'h2c, 8'h04, 8'h10, 32'h0000_0007, 8'h00);
    cmd(8'h01, 8'h2d, 8'h09, 8'h03, 32'h1234_5678, 8'h5a);
    cmd(8'h03, 8'h2d, 8'h09, 8'h03, 32'h1234_5678, 8'h00);
    cmd(8'h01, 8'h2b, 8'h00, 8'h03, 32'h0000_0001, 8'h00);
    test_done;
  end
  // Watchdog: about nine times the two thousand or so cycles the sequence needs.
  initial begin
    #400us;
    fail_count++;
    test_done;
  end
endmodule
